// ---- src/asc_regs.svh ----
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
// Behaviour
// (R1) memory holds 2,097,152 bytes, eight bits each
// (R2) write when select and write enable low
// (R3) read: select low, output enable low
// (R4) device floats data lines outside reads; the memory model drives the inverse of the last byte instead
// (R5) select high means standby, no access
// (R6) write spans overlap of select and enable
// (R7) host holds data stable across ending edge
// (R8) joint rise of select, enable: no drive
// (R9) host waits 1 ms after power-up
// (R10) address valid by select fall; enable high
// (R11) selected idle: no access, lines floating
// (R12) host drives all 21 address bits
// ==========================================================
// bus geometry
`define ASC_ADDR_W 21
`define ASC_DATA_W 8
// ==========================================================
// timing, clock 50 MHz
`define ASC_CLK_MHZ 50
`define ASC_SETTLE_US 1000
`define ASC_SETTLE_CYC (`ASC_SETTLE_US * `ASC_CLK_MHZ)
// timer count for write enable low; the pulse lasts one cycle more, 3 cycles (7 ns min -> 1 cycle)
`define ASC_WR_PULSE_CYC 2
// timer count for reads; sample comes 3 cycles after select and output enable low (10 ns max access)
`define ASC_RD_WAIT_CYC 2
`define ASC_CNT_W 16
`endif

// ---- src/asc_pkg.sv ----
package asc_pkg;
    typedef struct packed {
        logic we;
        logic [20:0] addr;
        logic [7:0] wdata;
    } asc_req_s;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [20:0] addr;
    } asc_pins_s;
    typedef enum logic [5:0] {
        ASC_SETTLE = 6'h01,
        ASC_IDLE = 6'h02,
        ASC_WR_SETUP = 6'h04,
        ASC_WR_PULSE = 6'h08,
        ASC_WR_END = 6'h10,
        ASC_RD = 6'h20
    } asc_state_e;
endpackage

// ---- src/asc_delay.sv ----
`timescale 1ns/100ps
`include "asc_regs.svh"
// ==========================================================
// down counter: loads a count, raises done when it reaches zero
module asc_delay (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic load,
    input wire logic [`ASC_CNT_W-1:0] count,
    output logic done
);
    logic [`ASC_CNT_W-1:0] cnt_r;
    logic [`ASC_CNT_W-1:0] cnt_nxt;

    // next count
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (load)
            cnt_nxt = count;
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - 16'h0001;
    end

    // register only
    always_ff @(posedge clock)
    begin
        if (!rstn)
            cnt_r <= '0;
        else if (ce)
            cnt_r <= cnt_nxt;
    end

    assign done = (cnt_r == '0) && !load;
endmodule

// ---- src/asc_host.sv ----
`timescale 1ns/100ps
`include "asc_regs.svh"
// ==========================================================
// host controller for the asynchronous 2M x 8 static memory
module asc_host (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic req_valid,
    output logic req_ready,
    input wire asc_pkg::asc_req_s req,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic ready_after_power,
    output asc_pkg::asc_pins_s pins,
    output logic [7:0] data_lines_o,
    output logic data_lines_oe_n,
    input wire logic [7:0] data_lines_i
);
    asc_pkg::asc_state_e st_r, st_nxt;
    asc_pkg::asc_pins_s pins_r, pins_nxt;
    logic [7:0] dout_r, dout_nxt;
    logic doe_n_r, doe_n_nxt;
    logic [7:0] rdat_r, rdat_nxt;
    logic rv_r, rv_nxt;
    logic load;
    logic [`ASC_CNT_W-1:0] count;
    logic done;
    logic armed_r;

    // one timer serves power settle, write pulse and read access
    asc_delay u_delay (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .load(load),
        .count(count),
        .done(done)
    );

    // ==========================================================
    // sequencer
    always_comb
    begin
        st_nxt = st_r;
        pins_nxt = pins_r;
        dout_nxt = dout_r;
        doe_n_nxt = doe_n_r;
        rdat_nxt = rdat_r;
        rv_nxt = 1'b0;
        load = 1'b0;
        count = '0;
        unique case (st_r)
            asc_pkg::ASC_SETTLE:
            begin
                // no access until the supply has settled [R9]
                if (!armed_r)
                begin
                    // timer is still zero from reset, so load the settle count first
                    load = 1'b1;
                    count = `ASC_CNT_W'(`ASC_SETTLE_CYC); // [R9]
                end
                else if (done)
                    st_nxt = asc_pkg::ASC_IDLE;
            end
            asc_pkg::ASC_IDLE:
            begin
                // deselected between accesses: standby, all strobes high [R5]
                pins_nxt.ce_n = 1'b1;
                pins_nxt.we_n = 1'b1;
                pins_nxt.oe_n = 1'b1;
                doe_n_nxt = 1'b1;
                if (req_valid)
                begin
                    pins_nxt.addr = req.addr; // full 21-bit address [R12]
                    if (req.we)
                    begin
                        // address and data out before the strobes fall [R7]
                        dout_nxt = req.wdata;
                        doe_n_nxt = 1'b0;
                        st_nxt = asc_pkg::ASC_WR_SETUP;
                    end
                    else
                    begin
                        // address goes out on the same edge that select falls [R10]
                        pins_nxt.ce_n = 1'b0;
                        pins_nxt.oe_n = 1'b0; // we stays high [R3]
                        load = 1'b1;
                        count = `ASC_CNT_W'(`ASC_RD_WAIT_CYC);
                        st_nxt = asc_pkg::ASC_RD;
                    end
                end
            end
            asc_pkg::ASC_WR_SETUP:
            begin
                // both low starts the write; oe left high [R2] [R6]
                pins_nxt.ce_n = 1'b0;
                pins_nxt.we_n = 1'b0;
                load = 1'b1;
                count = `ASC_CNT_W'(`ASC_WR_PULSE_CYC);
                st_nxt = asc_pkg::ASC_WR_PULSE;
            end
            asc_pkg::ASC_WR_PULSE:
            begin
                if (done)
                begin
                    // write enable ends the write, select stays low a cycle
                    // so the two never rise together [R6] [R8]
                    pins_nxt.we_n = 1'b1;
                    st_nxt = asc_pkg::ASC_WR_END;
                end
            end
            asc_pkg::ASC_WR_END:
            begin
                // data still driven past the ending edge for hold [R7]
                pins_nxt.ce_n = 1'b1;
                doe_n_nxt = 1'b1;
                st_nxt = asc_pkg::ASC_IDLE;
            end
            asc_pkg::ASC_RD:
            begin
                if (done)
                begin
                    rdat_nxt = data_lines_i;
                    rv_nxt = 1'b1;
                    pins_nxt.ce_n = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    st_nxt = asc_pkg::ASC_IDLE;
                end
            end
            default:
                st_nxt = asc_pkg::ASC_SETTLE;
        endcase
    end

    // register only; settle timer loads on the first enabled cycle after reset release
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            st_r <= asc_pkg::ASC_SETTLE;
            pins_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
            dout_r <= 8'h00;
            doe_n_r <= 1'b1;
            rdat_r <= 8'h00;
            rv_r <= 1'b0;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
            pins_r <= pins_nxt;
            dout_r <= dout_nxt;
            doe_n_r <= doe_n_nxt;
            rdat_r <= rdat_nxt;
            rv_r <= rv_nxt;
        end
    end

    // settle count loaded on first enabled cycle after reset
    always_ff @(posedge clock)
    begin
        if (!rstn)
            armed_r <= 1'b0;
        else if (ce)
            armed_r <= 1'b1;
    end

    assign req_ready = (st_r == asc_pkg::ASC_IDLE) && ce;
    assign ready_after_power = (st_r != asc_pkg::ASC_SETTLE);
    assign pins = pins_r;
    assign data_lines_o = dout_r;
    assign data_lines_oe_n = doe_n_r;
    assign rsp_valid = rv_r;
    assign rsp_data = rdat_r;
endmodule

// ---- tb/asc_host_chk.sv ----
`timescale 1ns/100ps
`include "asc_regs.svh"
// ==========================================
// pin rules that bind the host side
module asc_host_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_ready,
    input wire asc_pkg::asc_pins_s pins,
    input wire logic [7:0] data_lines_o,
    input wire logic data_lines_oe_n
);
    logic [15:0] cyc_r;
    logic [15:0] cyc_nxt;
    // cycles since reset, saturating once the settle time is over
    always_comb cyc_nxt = (cyc_r < `ASC_SETTLE_CYC) ? cyc_r + 16'h1 : cyc_r;
    always_ff @(posedge clock) cyc_r <= rstn ? cyc_nxt : 16'h0;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence wr_on;
        !pins.ce_n && !pins.we_n;
    endsequence
    settle_wait_a: assert property (cyc_r < `ASC_SETTLE_CYC |-> pins.ce_n && !req_ready)
        else $error("access before supply settle");
    write_drive_a: assert property (wr_on |-> !data_lines_oe_n)
        else $error("host not driving during write");
    data_hold_a: assert property (wr_on ##1 (pins.ce_n || pins.we_n)
        |-> $stable(data_lines_o) && $stable(pins.addr)) else $error("write end unstable");
    no_clash_a: assert property (!pins.ce_n && !pins.oe_n && pins.we_n |-> data_lines_oe_n)
        else $error("host drives during read");
    addr_hold_a: assert property ($past(!pins.ce_n) && !pins.ce_n |-> $stable(pins.addr))
        else $error("address moved while selected");
endmodule
bind asc_host asc_host_chk chk (.clock(clock), .rstn(rstn), .req_ready(req_ready),
    .pins(pins), .data_lines_o(data_lines_o), .data_lines_oe_n(data_lines_oe_n));

// ---- tb/asc_mem_model.sv ----
`timescale 1ns/100ps
// ==========================================
// behavioural 2M x 8 static memory, resolves the shared data lines
module asc_mem_model (
    input wire asc_pkg::asc_pins_s pins,
    input wire logic [7:0] host_d,
    input wire logic host_oe_n,
    output logic [7:0] bus
);
    logic [7:0] mem [logic [20:0]]; // sparse, saves 2M entries
    logic [7:0] last = 8'h00;
    // released lines show the inverse of the last byte, never a stale copy
    always @(pins or host_d or host_oe_n)
    begin
        if (!pins.ce_n && !pins.we_n && !host_oe_n)
            mem[pins.addr] = host_d;
        if (!host_oe_n)
            bus = host_d;
        else if (!pins.ce_n && !pins.oe_n && pins.we_n)
            bus = mem.exists(pins.addr) ? mem[pins.addr] : 8'h5a;
        else
            bus = ~last;
        last = bus;
    end
endmodule

// ---- tb/asc_host_bench.sv ----
`timescale 1ns/100ps
`include "asc_regs.svh"
// ==========================================
// self-checking bench for the static memory host
module asc_host_bench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    logic ce = 1'b1;
    asc_pkg::asc_req_s req = '0;
    logic req_ready, rsp_valid, ready_after_power, oe_n;
    logic [7:0] rsp_data, d_o, bus;
    asc_pkg::asc_pins_s pins;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    asc_host dut (.clock(clock), .rstn(rstn), .ce(ce), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .ready_after_power(ready_after_power), .pins(pins), .data_lines_o(d_o),
        .data_lines_oe_n(oe_n), .data_lines_i(bus));
    asc_mem_model mem (.pins(pins), .host_d(d_o), .host_oe_n(oe_n), .bus(bus));
    // clock, plus a ceiling above the settle wait
    always #10 clock = ~clock;
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 70000)
        begin
            fails++;
            results();
        end
    end
    task check(input string what, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task results();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one request held until taken; a read is judged on its response
    task access(input logic we, input logic [20:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        #1 req = '{we, a, d};
        req_valid = 1'b1;
        // ready looked at just after an edge, so it stands for the coming edge
        n = 0;
        while (req_ready !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            #1 n++;
        end
        check("request taken", 8'(req_ready), 8'h01);
        @(posedge clock);
        #1 req_valid = 1'b0;
        if (!we)
        begin
            n = 0;
            do
            begin
                @(posedge clock);
                #1;
            end
            while (rsp_valid !== 1'b1 && ++n < 8);
            check("read valid", 8'(rsp_valid), 8'h01);
            check("read byte", rsp_data, d);
        end
    endtask
    // clock enable low freezes the host: nothing taken, strobes stay high
    task t_freeze();
        @(posedge clock);
        #1 ce = 1'b0;
        req = '{1'b0, 21'h1fffff, 8'h00};
        req_valid = 1'b1;
        repeat (4)
        begin
            @(posedge clock);
            #1 check("frozen ready", 8'(req_ready), 8'h00);
            check("frozen select", 8'(pins.ce_n), 8'h01);
        end
        ce = 1'b1;
        req_valid = 1'b0;
        access(1'b0, 21'h1fffff, 8'h3c);
        $display("freeze test done");
    endtask
    task t_settle();
        int n;
        n = 0;
        check("power not ready", 8'(ready_after_power), 8'h00);
        while (req_ready !== 1'b1)
        begin
            @(posedge clock);
            n++;
        end
        check("settle wait", 8'(n >= `ASC_SETTLE_CYC), 8'h01);
        check("power ready", 8'(ready_after_power), 8'h01);
        $display("settle test done");
    endtask
    // both address ends and a mixed pattern, all written before any read
    task t_rw();
        logic [20:0] a [3] = '{21'h000000, 21'h1fffff, 21'h0aaaa5};
        logic [7:0] d [3] = '{8'ha5, 8'h3c, 8'hff};
        for (int i = 0; i < 3; i++)
            access(1'b1, a[i], d[i]);
        for (int i = 0; i < 3; i++)
            access(1'b0, a[i], d[i]);
        $display("read write test done");
    endtask
    initial
    begin
        repeat (3) @(posedge clock);
        #1 rstn = 1'b1;
        t_settle();
        t_rw();
        t_freeze();
        results();
    end
endmodule
